// ==== core/wgrc_regs.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - stepwise guide point keeps 3.175 mm margin
// - bit 13 one: offset register sets point
// - bit 13 zero: offset register not applied
// - bit 14 rise arms reset and timeout
// - clearing bit 14 in time adopts web position
// - timeout without clear keeps old guide point
// - reset honoured only manual and remote
// - bit 15 selects reversed error polarity
// - offset read as 16-bit two's complement
// - offset measured from window centre, right positive
// - one offset unit is 0.0635 mm
// - speed write with bit 15 takes value
// - speed write without bit 15 ignored
// - acceleration write with bit 7 takes value
// - acceleration write without bit 7 ignored
// - bit 8 hands control to remote writer
// - bit 9 selects manual or automatic mode
module wgrc_regs #(
    parameter int unsigned GP_TIMEOUT_CYCLES = wgrc_pkg::GP_TIMEOUT_CYC,
    parameter logic [6:0]  SPEED_INIT        = wgrc_pkg::RATE_RESET,
    parameter logic [6:0]  ACCEL_INIT        = wgrc_pkg::RATE_RESET
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,

    // register write port from the fieldbus side
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_sel,
    input  wire logic [15:0] wr_data,

    // register read port
    input  wire logic [1:0]  rd_sel,
    output logic      [15:0] rd_data,

    // sensing side, in offset units
    input  wire logic [15:0] web_pos,
    input  wire logic [15:0] window_half,

    // control outputs towards the guiding loop
    output logic             remote_ctrl,
    output logic             auto_mode,
    output logic             reverse_pol,
    output logic             gross_active,
    output logic      [15:0] guide_point,
    output logic      [6:0]  actuator_speed,
    output logic      [6:0]  actuator_accel,

    // guide point reset status
    output logic             gp_reset_armed,
    output logic             gp_reset_done,
    output logic             gp_reset_timeout
);

    // ********************************************************
    // storage
    // ********************************************************
    wgrc_pkg::wgrc_cmd_s    cmd_reg;
    logic [15:0]            offset_reg;
    logic [6:0]             speed_reg;
    logic [6:0]             accel_reg;
    logic signed [15:0]     step_point_reg;
    logic signed [15:0]     guide_point_reg;
    logic [15:0]            rd_data_reg;
    wgrc_pkg::wgrc_gpr_e    gpr_state_reg;
    wgrc_pkg::wgrc_gpr_e    gpr_state_next;
    logic                   done_reg;
    logic                   timeout_reg;

    // write strobes per register
    logic wr_cmd;
    logic wr_offset;
    logic wr_speed;
    logic wr_accel;

    assign wr_cmd    = wr_en && (wr_sel == wgrc_pkg::SEL_COMMAND);
    assign wr_offset = wr_en && (wr_sel == wgrc_pkg::SEL_OFFSET);
    assign wr_speed  = wr_en && (wr_sel == wgrc_pkg::SEL_SPEED);
    assign wr_accel  = wr_en && (wr_sel == wgrc_pkg::SEL_ACCEL);

    // ********************************************************
    // command register
    // ********************************************************
    // reserved low byte is never stored, so it reads as zero
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            cmd_reg <= wgrc_pkg::CMD_RESET;
        else if (wr_cmd)
            cmd_reg <= wr_data & wgrc_pkg::CMD_WR_MASK;
    end

    // plain level fields straight from the register
    assign remote_ctrl = cmd_reg.remote;
    assign auto_mode   = cmd_reg.auto_mode;
    assign reverse_pol = cmd_reg.reverse_pol;

    // ********************************************************
    // momentary bit edges
    // ********************************************************
    // edges are taken from the stored bits, so a bit held at one
    // across many writes still gives one action
    logic [2:0] mom_level;
    logic [2:0] mom_rise;
    logic [2:0] mom_fall;

    assign mom_level = {cmd_reg.gp_reset, cmd_reg.step_inc,
                        cmd_reg.step_dec};

    wgrc_edge #(
        .WIDTH (3)
    ) u_edge (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .level   (mom_level),
        .rise    (mom_rise),
        .fall    (mom_fall)
    );

    logic dec_rise;
    logic inc_rise;
    logic gpr_rise;
    logic gpr_fall;

    assign dec_rise = mom_rise[0];
    assign inc_rise = mom_rise[1];
    assign gpr_rise = mom_rise[2];
    assign gpr_fall = mom_fall[2];

    // ********************************************************
    // guide point offset register
    // ********************************************************
    // stored whatever bit 13 says; only its use is gated
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            offset_reg <= wgrc_pkg::OFFSET_RESET;
        else if (wr_offset)
            offset_reg <= wr_data;
    end

    // ********************************************************
    // actuator speed and acceleration
    // ********************************************************
    logic [6:0] speed_in;
    logic [6:0] accel_in;

    assign speed_in = wr_data[wgrc_pkg::SPD_LSB +: wgrc_pkg::RATE_W];
    assign accel_in = wr_data[wgrc_pkg::ACC_LSB +: wgrc_pkg::RATE_W];

    // out-of-range rates are clamped rather than refused
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            speed_reg <= SPEED_INIT;
        else if (wr_speed && wr_data[wgrc_pkg::SPD_GATE])
            speed_reg <= (speed_in > wgrc_pkg::RATE_MAX) ?
                         wgrc_pkg::RATE_MAX : speed_in;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            accel_reg <= ACCEL_INIT;
        else if (wr_accel && wr_data[wgrc_pkg::ACC_GATE])
            accel_reg <= (accel_in > wgrc_pkg::RATE_MAX) ?
                         wgrc_pkg::RATE_MAX : accel_in;
    end

    assign actuator_speed = speed_reg;
    assign actuator_accel = accel_reg;

    // ********************************************************
    // stepwise adjustment limit
    // ********************************************************
    // the limit shrinks to zero on a window narrower than the
    // margin, so steps then hold the point at the centre
    localparam logic [15:0] MARGIN = 16'(wgrc_pkg::MARGIN_UNITS);
    localparam logic signed [17:0] STEP =
        18'(wgrc_pkg::STEP_UNITS);

    logic signed [17:0] limit;
    logic signed [17:0] step_wide;
    logic signed [17:0] step_sum;

    assign limit = (window_half > MARGIN) ?
                   $signed({2'b00, window_half - MARGIN}) :
                   18'sd0;

    always_comb
    begin
        step_wide = 18'(step_point_reg);
        if (inc_rise && !dec_rise)
            step_sum = step_wide + STEP;
        else if (dec_rise && !inc_rise)
            step_sum = step_wide - STEP;
        else
            step_sum = step_wide;
        if (step_sum > limit)
            step_sum = limit;
        else if (step_sum < -limit)
            step_sum = -limit;
    end

    // ********************************************************
    // guide point reset sequence
    // ********************************************************
    logic gpr_allowed;
    logic tmr_running;
    logic tmr_expired;
    logic tmr_start;
    logic tmr_cancel;

    // only a remote-controlled guide in manual mode may reset
    assign gpr_allowed = cmd_reg.remote && !cmd_reg.auto_mode;
    assign tmr_start   = (gpr_state_reg == wgrc_pkg::GPR_IDLE) &&
                         gpr_rise && gpr_allowed;
    assign tmr_cancel  = (gpr_state_reg == wgrc_pkg::GPR_ARMED) &&
                         (gpr_fall || !gpr_allowed);

    wgrc_timer #(
        .CYCLES (GP_TIMEOUT_CYCLES)
    ) u_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .start   (tmr_start),
        .cancel  (tmr_cancel),
        .running (tmr_running),
        .expired (tmr_expired)
    );

    // next state of the reset sequence
    always_comb
    begin
        gpr_state_next = gpr_state_reg;
        case (gpr_state_reg)
            wgrc_pkg::GPR_IDLE:
                if (tmr_start)
                    gpr_state_next = wgrc_pkg::GPR_ARMED;
            wgrc_pkg::GPR_ARMED:
                if (tmr_cancel || tmr_expired || !tmr_running)
                    gpr_state_next = wgrc_pkg::GPR_IDLE;
            default:
                gpr_state_next = wgrc_pkg::GPR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            gpr_state_reg <= wgrc_pkg::GPR_IDLE;
        else
            gpr_state_reg <= gpr_state_next;
    end

    // commit happens only on a clear seen while still armed
    logic gpr_commit;
    assign gpr_commit = (gpr_state_reg == wgrc_pkg::GPR_ARMED) &&
                        gpr_fall && gpr_allowed;

    // one-cycle outcome pulses
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done_reg    <= 1'b0;
            timeout_reg <= 1'b0;
        end
        else
        begin
            done_reg    <= gpr_commit;
            timeout_reg <= (gpr_state_reg == wgrc_pkg::GPR_ARMED) &&
                           tmr_expired && !gpr_fall;
        end
    end

    assign gp_reset_armed   = (gpr_state_reg == wgrc_pkg::GPR_ARMED);
    assign gp_reset_done    = done_reg;
    assign gp_reset_timeout = timeout_reg;

    // ********************************************************
    // stepwise guide point
    // ********************************************************
    // steps only in automatic mode; reset commit overrides a step
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            step_point_reg <= 16'sh0000;
        else if (gpr_commit)
            step_point_reg <= $signed(web_pos);
        else if (cmd_reg.auto_mode && (inc_rise || dec_rise))
            step_point_reg <= 16'(step_sum);
    end

    // ********************************************************
    // applied guide point
    // ********************************************************
    // signed units of 0.0635 mm from window centre, right positive;
    // a timed-out reset never touches step_point_reg, so the old
    // point simply stays
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            guide_point_reg <= 16'sh0000;
        else if (cmd_reg.gross_en)
            guide_point_reg <= $signed(offset_reg);
        else
            guide_point_reg <= step_point_reg;
    end

    assign guide_point  = guide_point_reg;
    assign gross_active = cmd_reg.gross_en;

    // ********************************************************
    // read back
    // ********************************************************
    // read data is registered: it appears one cycle after rd_sel
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rd_data_reg <= 16'h0000;
        else
        begin
            case (rd_sel)
                wgrc_pkg::SEL_COMMAND:
                    rd_data_reg <= cmd_reg;
                wgrc_pkg::SEL_OFFSET:
                    rd_data_reg <= offset_reg;
                wgrc_pkg::SEL_SPEED:
                    rd_data_reg <= {1'b0, speed_reg, 8'h00};
                wgrc_pkg::SEL_ACCEL:
                    rd_data_reg <= {8'h00, 1'b0, accel_reg};
                default:
                    rd_data_reg <= 16'h0000;
            endcase
        end
    end

    assign rd_data = rd_data_reg;

endmodule : wgrc_regs

// ==== core/wgrc_pkg.sv ====
package wgrc_pkg;

    // ********************************************************
    // register select codes for the write and read ports
    // ********************************************************
    localparam int unsigned   SEL_W          = 2;
    localparam logic [1:0]    SEL_COMMAND    = 2'h0;
    localparam logic [1:0]    SEL_OFFSET     = 2'h1;
    localparam logic [1:0]    SEL_SPEED      = 2'h2;
    localparam logic [1:0]    SEL_ACCEL      = 2'h3;

    // ********************************************************
    // field layouts and reset values
    // ********************************************************
    localparam logic [15:0]   CMD_WR_MASK    = 16'hff00;
    localparam logic [15:0]   CMD_RESET      = 16'h0000;
    localparam logic [15:0]   OFFSET_RESET   = 16'h0000;
    localparam int unsigned   SPD_GATE       = 15;
    localparam int unsigned   SPD_LSB        = 8;
    localparam int unsigned   ACC_GATE       = 7;
    localparam int unsigned   ACC_LSB        = 0;
    localparam int unsigned   RATE_W         = 7;
    localparam logic [6:0]    RATE_MAX       = 7'h64;
    localparam logic [6:0]    RATE_RESET     = 7'h32;

    // ********************************************************
    // distances, in nanometres, and offset units
    // ********************************************************
    localparam int unsigned   UNIT_NM        = 63500;
    localparam int unsigned   MARGIN_NM      = 3175000;
    localparam int unsigned   STEP_NM        = 254000;
    localparam int unsigned   MARGIN_UNITS   =
        (MARGIN_NM + UNIT_NM - 1) / UNIT_NM;
    localparam int unsigned   STEP_UNITS     = STEP_NM / UNIT_NM;

    // ********************************************************
    // guide point reset timeout
    // ********************************************************
    localparam int unsigned   CLK_KHZ        = 250000;
    localparam int unsigned   GP_TIMEOUT_MS  = 2000;
    localparam int unsigned   GP_TIMEOUT_CYC = GP_TIMEOUT_MS * CLK_KHZ;

    // ********************************************************
    // command word, laid out as on the wire
    // ********************************************************
    typedef struct packed {
        logic       reverse_pol;
        logic       gp_reset;
        logic       gross_en;
        logic       servo_set;
        logic       step_inc;
        logic       step_dec;
        logic       auto_mode;
        logic       remote;
        logic [7:0] reserved;
    } wgrc_cmd_s;

    // guide point reset sequence
    typedef enum logic [0:0] {
        GPR_IDLE  = 1'b0,
        GPR_ARMED = 1'b1
    } wgrc_gpr_e;

endpackage : wgrc_pkg

// ==== core/wgrc_edge.sv ====
`timescale 1ns/1ps
module wgrc_edge #(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // level in, edge pulses out
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    // ********************************************************
    // one edge detector per bit
    // ********************************************************
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic last_reg;

            // previous level, cleared by reset
            always_ff @(posedge clk_sys or negedge reset_n)
            begin
                if (!reset_n)
                    last_reg <= 1'b0;
                else
                    last_reg <= level[i];
            end

            assign rise[i] = level[i] & ~last_reg;
            assign fall[i] = ~level[i] & last_reg;
        end
    endgenerate

endmodule : wgrc_edge

// ==== core/wgrc_timer.sv ====
`timescale 1ns/1ps
module wgrc_timer #(
    parameter int unsigned CYCLES = 16
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // control
    input  wire logic start,
    input  wire logic cancel,
    // status
    output logic      running,
    output logic      expired
);

    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);

    logic [W-1:0] count_reg;

    // ********************************************************
    // down counter; start wins over cancel
    // ********************************************************
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            count_reg <= '0;
        else if (start)
            count_reg <= LOAD;
        else if (cancel)
            count_reg <= '0;
        else if (count_reg != '0)
            count_reg <= count_reg - W'(1);
    end

    assign running = (count_reg != '0);
    assign expired = (count_reg == W'(1)) & ~start & ~cancel;

endmodule : wgrc_timer

// ==== sim/wgrc_writer.sv ====
`timescale 1ns/1ps
// ********************************************************
// remote writer standing on the fieldbus side
// ********************************************************
module wgrc_writer (
    // clock
    input  wire logic        clk_sys,
    // register write port
    output logic             wr_en,
    output logic      [1:0]  wr_sel,
    output logic      [15:0] wr_data,
    // sensing values seen by the guide
    output logic      [15:0] web_pos,
    output logic      [15:0] window_half
);
    // idle values from time zero
    initial
    begin
        wr_en       = 1'b0;
        wr_sel      = 2'h0;
        wr_data     = 16'h0000;
        web_pos     = 16'h0000;
        window_half = 16'h0400;
    end

    // one whole word per write, never two writes in one cycle
    task wr(input logic [1:0] sel, input logic [15:0] data);
        @(posedge clk_sys);
        wr_en   <= 1'b1;
        wr_sel  <= sel;
        wr_data <= data;
        @(posedge clk_sys);
        wr_en   <= 1'b0;
        wr_data <= ~data; // idle bus must not look like the last word
    endtask : wr

    // web position and window move with the system clock
    task set_sense(input logic [15:0] pos, input logic [15:0] half);
        @(posedge clk_sys);
        web_pos     <= pos;
        window_half <= half;
    endtask : set_sense
endmodule : wgrc_writer

// ==== sim/wgrc_regs_chk.sv ====
`timescale 1ns/1ps
module wgrc_regs_chk #(
    parameter int unsigned GP_TIMEOUT_CYCLES = 20
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // write port
    input  wire logic        wr_en,
    input  wire logic [1:0]  wr_sel,
    input  wire logic [15:0] wr_data,
    // guiding outputs
    input  wire logic        remote_ctrl,
    input  wire logic        auto_mode,
    input  wire logic        reverse_pol,
    input  wire logic        gross_active,
    input  wire logic [15:0] guide_point,
    input  wire logic [6:0]  actuator_speed,
    input  wire logic [6:0]  actuator_accel,
    // guide point reset status
    input  wire logic        gp_reset_armed,
    input  wire logic        gp_reset_done,
    input  wire logic        gp_reset_timeout
);
    // ********************************************************
    // helpers
    // ********************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    wire cmd_wr = wr_en && wr_sel == wgrc_pkg::SEL_COMMAND;
    wire off_wr = wr_en && wr_sel == wgrc_pkg::SEL_OFFSET;
    wire spd_wr = wr_en && wr_sel == wgrc_pkg::SEL_SPEED;
    wire acc_wr = wr_en && wr_sel == wgrc_pkg::SEL_ACCEL;
    logic [31:0] armed_cnt;
    // expected rates, clamped at 100
    wire [6:0] spd_new = (wr_data[14:8] > 7'd100) ? 7'd100 : wr_data[14:8];
    wire [6:0] acc_new = (wr_data[6:0] > 7'd100) ? 7'd100 : wr_data[6:0];

    // length of the armed window, so a stuck timer shows up
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            armed_cnt <= 32'h0000_0000;
        else if (!gp_reset_armed)
            armed_cnt <= 32'h0000_0000;
        else
            armed_cnt <= armed_cnt + 32'h0000_0001;
    end

    // ********************************************************
    // properties
    // ********************************************************
    chk_remote_bit: assert property (
        cmd_wr |=> remote_ctrl == $past(wr_data[8]))
        else $error("remote bit lost");
    chk_mode_bit: assert property (
        cmd_wr |=> auto_mode == $past(wr_data[9]))
        else $error("mode bit lost");
    chk_pol_bit: assert property (
        cmd_wr |=> reverse_pol == $past(wr_data[15]))
        else $error("polarity bit lost");
    chk_gross_bit: assert property (
        cmd_wr |=> gross_active == $past(wr_data[13]))
        else $error("gross bit lost");
    chk_gross_point: assert property (
        off_wr && gross_active ##1 (gross_active && !off_wr)
        |=> guide_point == $past(wr_data, 2))
        else $error("offset not applied");
    chk_speed_take: assert property (
        spd_wr && wr_data[15] |=> actuator_speed == $past(spd_new))
        else $error("speed not taken");
    chk_speed_gate: assert property (
        spd_wr && !wr_data[15] |=> $stable(actuator_speed))
        else $error("ungated speed taken");
    chk_accel_take: assert property (
        acc_wr && wr_data[7] |=> actuator_accel == $past(acc_new))
        else $error("acceleration not taken");
    chk_accel_gate: assert property (
        acc_wr && !wr_data[7] |=> $stable(actuator_accel))
        else $error("ungated acceleration taken");
    chk_rate_limit: assert property (
        actuator_speed <= 7'd100 && actuator_accel <= 7'd100)
        else $error("rate above limit");
    chk_arm_cond: assert property (
        $rose(gp_reset_armed) |-> $past(remote_ctrl) && !$past(auto_mode))
        else $error("armed outside manual remote");
    chk_done_armed: assert property (
        gp_reset_done |-> $past(gp_reset_armed) ##1 !gp_reset_done)
        else $error("commit without armed routine");
    chk_tmo_len: assert property (
        armed_cnt <= GP_TIMEOUT_CYCLES + 2)
        else $error("armed past timeout");
    chk_tmo_keep: assert property (
        gp_reset_timeout && !gross_active |-> $past(gp_reset_armed)
        ##1 (!gp_reset_armed && $stable(guide_point)))
        else $error("timeout moved point or stayed armed");

    // main scenarios reached
    cov_commit: cover property (gp_reset_done);
    cov_timeout: cover property (gp_reset_timeout);
    cov_clamp: cover property (
        spd_wr && wr_data[15] && wr_data[14:8] > 7'd100);
endmodule : wgrc_regs_chk

bind wgrc_regs wgrc_regs_chk #(
    .GP_TIMEOUT_CYCLES(GP_TIMEOUT_CYCLES)
) wgrc_regs_chk_i (.*);

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    // ********************************************************
    // signals and instances
    // ********************************************************
    localparam int unsigned TMO = 20;
    logic        clk_sys = 1'b0;
    logic        reset_n;
    logic [1:0]  rd_sel;
    logic [15:0] rd_data, web_pos, window_half, wr_data, guide_point;
    logic [1:0]  wr_sel;
    logic        wr_en, remote_ctrl, auto_mode, reverse_pol, gross_active;
    logic [6:0]  actuator_speed, actuator_accel;
    logic        gp_reset_armed, gp_reset_done, gp_reset_timeout;
    logic        arm_seen, done_seen, tmo_seen;
    int          err_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    // rate writes: speed gated by bit 15, acceleration by bit 7
    logic [1:0]  r_sel [6] = '{2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
    logic [15:0] r_dat [6] = '{16'hbc00, 16'h1400, 16'hff00,
                               16'h00bc, 16'h0014, 16'h00ff};
    logic [15:0] r_exp [6] = '{16'h3c00, 16'h3c00, 16'h6400,
                               16'h003c, 16'h003c, 16'h0064};
    // step commands; inc held across the first two writes, dec dropped before each raise
    logic [15:0] s_cmd [8] = '{16'h0b00, 16'h0b00, 16'h0300, 16'h0700,
                               16'h0300, 16'h0700, 16'h0300, 16'h0700};
    logic [15:0] s_exp [8] = '{16'h0004, 16'h0004, 16'h0004, 16'h0000,
                               16'h0000, 16'hfffc, 16'hfffc, 16'hfffc};

    always #2 clk_sys = ~clk_sys;

    wgrc_writer wgrc_writer_i (.*);

    wgrc_regs #(.GP_TIMEOUT_CYCLES(TMO)) wgrc_regs_i (.*);

    // ********************************************************
    // tasks
    // ********************************************************
    task check(input logic [15:0] got, input logic [15:0] exp,
               input string what);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what,
                     got, exp);
        end
    endtask : check

    // one register write through the remote writer
    task wr(input logic [1:0] sel, input logic [15:0] data);
        wgrc_writer_i.wr(sel, data);
    endtask : wr

    // read data lands one cycle after the select is driven
    task rd_chk(input logic [1:0] sel, input logic [15:0] exp,
                input string what);
        @(posedge clk_sys);
        rd_sel <= sel;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check(rd_data, exp, what);
    endtask : rd_chk

    task settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : settle

    // pulses last one cycle, so every cycle is looked at
    task watch(input int n);
        arm_seen = 1'b0;
        done_seen = 1'b0;
        tmo_seen = 1'b0;
        repeat (n)
        begin
            @(negedge clk_sys);
            arm_seen |= gp_reset_armed;
            done_seen |= gp_reset_done;
            tmo_seen |= gp_reset_timeout;
        end
    endtask : watch

    task results;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    // a hang costs a mismatch and ends the run
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            results();
        end
    end

    // main sequence
    initial
    begin
        reset_n = 1'b0;
        rd_sel = 2'h0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_chk(2'h0, 16'h0000, "command reset");
        rd_chk(2'h1, 16'h0000, "offset reset");
        rd_chk(2'h2, 16'h3200, "speed reset");
        rd_chk(2'h3, 16'h0032, "accel reset");
        $display("test reset done");
        wr(2'h0, 16'h03ff);
        settle(1);
        check(16'(remote_ctrl), 16'h0001, "remote");
        check(16'(auto_mode), 16'h0001, "auto");
        rd_chk(2'h0, 16'h0300, "command readback");
        wr(2'h0, 16'h8300);
        settle(1);
        check(16'(reverse_pol), 16'h0001, "reversed");
        wr(2'h0, 16'h0300);
        settle(1);
        check(16'(reverse_pol), 16'h0000, "standard");
        $display("test command done");
        for (int i = 0; i < 6; i++)
        begin
            wr(r_sel[i], r_dat[i]);
            rd_chk(r_sel[i], r_exp[i], "rate");
        end
        $display("test rates done");
        wr(2'h0, 16'h0100);
        wgrc_writer_i.set_sense(16'h0123, 16'h0400);
        wr(2'h0, 16'h4100);
        watch(4);
        check(16'(arm_seen), 16'h0001, "armed");
        wr(2'h0, 16'h0100);
        watch(4);
        check(16'(done_seen), 16'h0001, "commit");
        check(guide_point, 16'h0123, "new point");
        wgrc_writer_i.set_sense(16'h0200, 16'h0400);
        wr(2'h0, 16'h4100);
        watch(TMO + 8);
        check(16'(tmo_seen), 16'h0001, "timeout");
        check(guide_point, 16'h0123, "point kept");
        wr(2'h0, 16'h0100);
        watch(4);
        check(16'(done_seen), 16'h0000, "late clear");
        $display("test guide point reset done");
        wr(2'h0, 16'h4000);
        watch(6);
        check(16'(arm_seen), 16'h0000, "local arm");
        wr(2'h0, 16'h0000);
        wr(2'h0, 16'h0300);
        wr(2'h0, 16'h4300);
        watch(6);
        check(16'(arm_seen), 16'h0000, "auto arm");
        wr(2'h0, 16'h0300);
        $display("test reset gating done");
        wgrc_writer_i.set_sense(16'h0123, 16'h0036);
        for (int i = 0; i < 8; i++)
        begin
            wr(2'h0, s_cmd[i]);
            settle(3);
            check(guide_point, s_exp[i], "step");
        end
        $display("test steps done");
        wr(2'h1, 16'hfff0);
        wr(2'h0, 16'h2300);
        settle(2);
        check(16'(gross_active), 16'h0001, "gross on");
        check(guide_point, 16'hfff0, "left offset");
        wr(2'h1, 16'h0010);
        settle(2);
        check(guide_point, 16'h0010, "right offset");
        rd_chk(2'h1, 16'h0010, "offset readback");
        wr(2'h0, 16'h0300);
        settle(2);
        check(16'(gross_active), 16'h0000, "gross off");
        check(guide_point, 16'hfffc, "offset dropped");
        $display("test gross done");
        results();
    end
endmodule : tb_top
